// >>> iep_map.svh
// register offsets, field positions, reset values and masks
// Notes on behaviour
// RL1: bits 3..0 of enable group 1 gate four second-bank sources.
// RL2: reserved upper bits read undefined (zero here); never write ones there.
// RL3: priority-low group 0 holds the low priority bit of seven sources.
// RL4: priority-low group 1 holds the low priority bit of four sources.
// RL5: reset clears every implemented bit of the three registers.
// RL6: each register supports single-bit set, clear and test besides bytes.
// RL7: high and low priority bits form a level from 0 (lowest) to 3.
// RL8: only a higher level preempts a running handler; level 3 never is.
// RL9: per-source enables act only while the global gate is set.
`ifndef IEP_MAP_SVH
`define IEP_MAP_SVH
`define IEP_OFS_PRIO_LO0 8'hb8
`define IEP_OFS_IRQ_EN1 8'he8
`define IEP_OFS_PRIO_LO1 8'hf8
`define IEP_OFS_IRQ_EN0 8'ha8
`define IEP_OFS_PRIO_HI0 8'hb7
`define IEP_OFS_PRIO_HI1 8'hf7
`define IEP_OFS_STATUS 8'hf0
`define IEP_MASK_GRP0 8'h7f
`define IEP_MASK_GRP1 8'h0f
`define IEP_RST_VAL 8'h00
`define IEP_GATE_BIT 7
`define IEP_SRC_CNT 11
`endif

// >>> iep_pkg.sv
// types shared by the interrupt enable and priority block
package iep_pkg;
	typedef logic [1:0] iep_level_t;
	typedef logic [7:0] iep_byte_t;
	typedef enum logic [1:0] {
		IEP_OP_BYTE,
		IEP_OP_SET,
		IEP_OP_CLR
	} iep_op_e;
endpackage

// >>> iep_arb_if.sv
// carrier between register file and arbiter
`timescale 1ns/1ns
interface iep_arb_if;
	logic [10:0] req;
	logic [10:0] en;
	logic [10:0] prio_hi;
	logic [10:0] prio_lo;
	logic gate;
	logic ack;
	logic ret;
	logic grant_valid;
	logic [3:0] grant_id;
	logic [1:0] grant_level;
	logic [3:0] active;
	modport regs (output en, prio_hi, prio_lo, gate,
		input grant_valid, grant_id, grant_level, active);
	modport arb (input req, en, prio_hi, prio_lo, gate, ack, ret,
		output grant_valid, grant_id, grant_level, active);
endinterface

// >>> iep_arbiter.sv
// priority arbiter with in-service level stack
`timescale 1ns/1ns
`include "iep_map.svh"
module iep_arbiter (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	iep_arb_if.arb bus
);
	import iep_pkg::*;
	logic [3:0] next_id;
	logic [1:0] next_lvl;
	logic next_vld;
	logic [1:0] top_lvl;
	logic any_act;

	// highest active level is the running handler
	always_comb begin
		any_act = |bus.active;
		top_lvl = 2'd0;
		for (int l = 0; l < 4; l++) begin
			if (bus.active[l]) begin
				top_lvl = 2'(l);
			end
		end
	end

	// lowest index wins inside a level (polling order)
	always_comb begin
		next_vld = 1'b0;
		next_id = 4'h0;
		next_lvl = 2'd0;
		for (int i = `IEP_SRC_CNT - 1; i >= 0; i--) begin
			if (bus.gate && bus.req[i] && bus.en[i]) begin // [RL9]
				if (!next_vld || {bus.prio_hi[i], bus.prio_lo[i]} >= next_lvl) begin
					next_vld = 1'b1;
					next_id = 4'(i);
					next_lvl = {bus.prio_hi[i], bus.prio_lo[i]}; // [RL7]
				end
			end
		end
		if (any_act && next_lvl <= top_lvl) begin
			next_vld = 1'b0; // [RL8]
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			bus.grant_valid <= 1'b0;
			bus.grant_id <= 4'h0;
			bus.grant_level <= 2'd0;
		end else begin
			bus.grant_valid <= next_vld;
			bus.grant_id <= next_id;
			bus.grant_level <= next_lvl;
		end
	end

	// ack pushes granted level, return pops the top one
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			bus.active <= 4'h0;
		end else begin
			// a return and a new grant in one cycle: pop, then push
			if (bus.ret && any_act) begin
				bus.active[top_lvl] <= 1'b0;
			end
			if (bus.ack && bus.grant_valid) begin
				bus.active[bus.grant_level] <= 1'b1; // [RL8]
			end
		end
	end
endmodule

// >>> iep_regs.sv
// second enable bank and low priority registers with arbitration
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`include "iep_map.svh"
module iep_regs (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire iep_pkg::iep_byte_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire iep_pkg::iep_op_e op_i,
	input wire logic [2:0] bit_sel_i,
	output iep_pkg::iep_byte_t rdata_o,
	output logic bit_o,
	// interrupt requests and core handshake
	input wire logic [10:0] irq_req_i,
	input wire logic irq_ack_i,
	input wire logic irq_ret_i,
	output logic irq_valid_o,
	output logic [3:0] irq_id_o,
	output logic [1:0] irq_level_o
);
	import iep_pkg::*;
	iep_byte_t en0, en1, plo0, plo1, phi0, phi1;
	iep_byte_t rd_val;
	iep_arb_if arb_c ();

	// byte write, or bit set / bit clear on one bit
	function automatic iep_byte_t upd(iep_byte_t cur, iep_byte_t mask);
		iep_byte_t v;
		v = cur;
		unique case (op_i)
			IEP_OP_BYTE: v = wdata_i;
			IEP_OP_SET: v[bit_sel_i] = 1'b1; // [RL6]
			IEP_OP_CLR: v[bit_sel_i] = 1'b0; // [RL6]
			default: v = cur;
		endcase
		return v & mask; // [RL2]
	endfunction

	function automatic logic hit(logic [7:0] ofs);
		return wr_i && addr_i == ofs;
	endfunction

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			en1 <= `IEP_RST_VAL; // [RL5]
		end else if (hit(`IEP_OFS_IRQ_EN1)) begin
			en1 <= upd(en1, `IEP_MASK_GRP1); // [RL1]
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			plo0 <= `IEP_RST_VAL; // [RL5]
		end else if (hit(`IEP_OFS_PRIO_LO0)) begin
			plo0 <= upd(plo0, `IEP_MASK_GRP0); // [RL3]
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			plo1 <= `IEP_RST_VAL; // [RL5]
		end else if (hit(`IEP_OFS_PRIO_LO1)) begin
			plo1 <= upd(plo1, `IEP_MASK_GRP1); // [RL4]
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			en0 <= `IEP_RST_VAL;
		end else if (hit(`IEP_OFS_IRQ_EN0)) begin
			en0 <= upd(en0, 8'hff);
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			phi0 <= `IEP_RST_VAL;
		end else if (hit(`IEP_OFS_PRIO_HI0)) begin
			phi0 <= upd(phi0, `IEP_MASK_GRP0);
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			phi1 <= `IEP_RST_VAL;
		end else if (hit(`IEP_OFS_PRIO_HI1)) begin
			phi1 <= upd(phi1, `IEP_MASK_GRP1);
		end
	end

	// source order: 0..6 first bank, 7..10 second bank
	assign arb_c.req = irq_req_i;
	assign arb_c.ack = irq_ack_i;
	assign arb_c.ret = irq_ret_i;
	assign arb_c.gate = en0[`IEP_GATE_BIT]; // [RL9]
	assign arb_c.en = {en1[3:0], en0[6:0]}; // [RL1]
	assign arb_c.prio_lo = {plo1[3:0], plo0[6:0]}; // [RL3] [RL4]
	assign arb_c.prio_hi = {phi1[3:0], phi0[6:0]}; // [RL7]

	iep_arbiter u_arb (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.bus(arb_c)
	);

	// unmapped addresses read zero; status shows in-service levels
	always_comb begin
		unique case (addr_i)
			`IEP_OFS_IRQ_EN0: rd_val = en0;
			`IEP_OFS_IRQ_EN1: rd_val = en1;
			`IEP_OFS_PRIO_LO0: rd_val = plo0;
			`IEP_OFS_PRIO_LO1: rd_val = plo1;
			`IEP_OFS_PRIO_HI0: rd_val = phi0;
			`IEP_OFS_PRIO_HI1: rd_val = phi1;
			`IEP_OFS_STATUS: rd_val = {4'h0, arb_c.active};
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rdata_o <= 8'h00;
			bit_o <= 1'b0;
		end else begin
			rdata_o <= rd_i ? rd_val : 8'h00;
			bit_o <= rd_i ? rd_val[bit_sel_i] : 1'b0; // [RL6]
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_valid_o <= 1'b0;
			irq_id_o <= 4'h0;
			irq_level_o <= 2'd0;
		end else begin
			irq_valid_o <= arb_c.grant_valid;
			irq_id_o <= arb_c.grant_id;
			irq_level_o <= arb_c.grant_level;
		end
	end
endmodule

// >>> iep_sva.sv
// checker on the register block ports
`timescale 1ns/1ns
module iep_sva (
	// clock, reset and register port
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic rd_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic [7:0] rdata_o,
	input wire logic bit_o,
	// interrupt side
	input wire logic [10:0] irq_req_i,
	input wire logic irq_ack_i,
	input wire logic irq_ret_i,
	input wire logic irq_valid_o,
	input wire logic [3:0] irq_id_o,
	input wire logic [1:0] irq_level_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	a_en_reserved: assert property (
		rd_i && addr_i == 8'he8 |=> rdata_o[7:4] == 4'h0) else $error("e8 rsv");
	a_lo0_reserved: assert property (
		rd_i && addr_i == 8'hb8 |=> !rdata_o[7]) else $error("b8 rsv");
	a_lo1_reserved: assert property (
		rd_i && addr_i == 8'hf8 |=> rdata_o[7:4] == 4'h0) else $error("f8 rsv");
	a_bit_test: assert property (
		$past(rd_i) |-> bit_o == rdata_o[$past(bit_sel_i)]) else $error("bit");
	a_read_stands: assert property (
		!$past(rd_i) |-> rdata_o == 8'h00) else $error("rdata idle");
	a_reset_clean: assert property (
		!$past(rst_n_i) |-> rdata_o == 8'h00 && !irq_valid_o) else $error("rst");
	a_grant_cause: assert property (
		irq_valid_o |-> ($past(irq_req_i, 2) >> irq_id_o) & 1) else $error("id");
	a_top_level: assert property (
		irq_ack_i && irq_valid_o && irq_level_o == 2'h3 ##1 !irq_ret_i [*4]
		|-> !irq_valid_o) else $error("preempt");
endmodule
bind iep_regs iep_sva u_sva (
	.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i),
	.addr_i(addr_i),
	.rd_i(rd_i),
	.bit_sel_i(bit_sel_i),
	.rdata_o(rdata_o),
	.bit_o(bit_o),
	.irq_req_i(irq_req_i),
	.irq_ack_i(irq_ack_i),
	.irq_ret_i(irq_ret_i),
	.irq_valid_o(irq_valid_o),
	.irq_id_o(irq_id_o),
	.irq_level_o(irq_level_o)
);

// >>> iep_core.sv
// core model: takes a grant, runs a handler, returns
`timescale 1ns/1ns
module iep_core (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire logic irq_valid_i,
	output logic irq_ack_o,
	output logic irq_ret_o
);
	logic [3:0] cnt;
	always_ff @(posedge clk_sys_i) begin
		irq_ack_o <= 1'b0;
		irq_ret_o <= rst_n_i && cnt == 4'h1;
		if (!rst_n_i)
			cnt <= 4'h0;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
		else if (en_i && irq_valid_i) begin
			irq_ack_o <= 1'b1;
			cnt <= 4'h9;
		end
	end
endmodule

// >>> tb_top.sv
// bench for the enable and low priority registers
`timescale 1ns/1ns
module tb_top;
	import iep_pkg::*;
	logic clk_sys_i = 0, rst_n_i = 0, wr = 0, rd = 0, en = 0;
	logic ack, ret, bit_o, irq_valid_o;
	logic [7:0] addr = 0, wd = 0, rdata_o;
	logic [2:0] bs = 0;
	logic [10:0] req = 0;
	logic [3:0] irq_id_o;
	logic [1:0] irq_level_o;
	logic [6:0] grant;
	assign grant = {irq_valid_o, irq_id_o, irq_level_o};
	iep_op_e op = IEP_OP_BYTE;
	int miscompares = 0, checks_done = 0;
	// offset, write value, read back; no ones in reserved bits
	logic [23:0] rows [7] = '{24'he80a0a, 24'he80505, 24'hb85555,
		24'hb82a2a, 24'hf80505, 24'hf80a0a, 24'hc0ff00};
	always #4 clk_sys_i = ~clk_sys_i;
	iep_regs dut (.clk_sys_i, .rst_n_i, .addr_i(addr), .wdata_i(wd),
		.wr_i(wr), .rd_i(rd), .op_i(op), .bit_sel_i(bs), .rdata_o, .bit_o,
		.irq_req_i(req), .irq_ack_i(ack), .irq_ret_i(ret), .irq_valid_o,
		.irq_id_o, .irq_level_o);
	iep_core core (.clk_sys_i, .rst_n_i, .en_i(en),
		.irq_valid_i(irq_valid_o), .irq_ack_o(ack), .irq_ret_o(ret));
	task chk(string n, logic [8:0] g, logic [8:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task wr_reg(logic [7:0] a, logic [7:0] d, iep_op_e o = IEP_OP_BYTE,
		logic [2:0] b = 3'h0);
		@(posedge clk_sys_i);
		addr <= a;
		wd <= d;
		op <= o;
		bs <= b;
		wr <= 1;
		@(posedge clk_sys_i);
		wr <= 0;
	endtask
	task settle(int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	// bounded wait for the core to take a grant
	task wait_ack;
		for (int n = 0; n < 20 && ack !== 1'b1; n++) begin
			settle(1);
		end
	endtask
	// read data stand only in the cycle after the strobe
	task rd_reg(logic [7:0] a, logic [2:0] b = 3'h0);
		@(posedge clk_sys_i);
		addr <= a;
		bs <= b;
		rd <= 1;
		@(posedge clk_sys_i);
		rd <= 0;
		#1;
	endtask
	initial begin
		repeat (5) @(posedge clk_sys_i);
		rst_n_i <= 1;
		foreach (rows[i]) begin
			rd_reg(rows[i][23:16]);
			chk("reset", 9'(rdata_o), 9'h000);
		end
		foreach (rows[i]) begin
			wr_reg(rows[i][23:16], rows[i][15:8]);
			rd_reg(rows[i][23:16]);
			chk("byte", 9'(rdata_o), 9'(rows[i][7:0]));
		end
		wr_reg(8'he8, 8'h0f);
		wr_reg(8'he8, 8'h00, IEP_OP_CLR, 3'h2);
		rd_reg(8'he8, 3'h2);
		chk("clr", {bit_o, rdata_o}, 9'h00b);
		wr_reg(8'he8, 8'h00, IEP_OP_SET, 3'h2);
		rd_reg(8'he8, 3'h2);
		chk("set", {bit_o, rdata_o}, 9'h10f);
		wr_reg(8'ha8, 8'h80);
		wr_reg(8'he8, 8'h02);
		req <= 11'h180;
		for (int l = 0; l < 4; l++) begin
			wr_reg(8'hf7, {6'h0, l[1], 1'b0});
			wr_reg(8'hf8, {6'h0, l[0], 1'b0});
			settle(3);
			chk("lvl", 9'(grant), 9'({5'h18, l[1:0]}));
		end
		wr_reg(8'ha8, 8'h00);
		settle(3);
		chk("gate", 9'(irq_valid_o), 9'h000);
		wr_reg(8'ha8, 8'h80);
		wr_reg(8'he8, 8'h01);
		settle(3);
		chk("pick", 9'(grant[6:2]), 9'h017);
		// level 0 handler runs, a level 3 source must cut in
		@(posedge clk_sys_i);
		en <= 1;
		wait_ack;
		chk("ack0", 9'({ack, grant[5:0]}), 9'h05c);
		@(posedge clk_sys_i);
		en <= 0;
		wr_reg(8'he8, 8'h03);
		settle(3);
		chk("preempt", 9'(grant), 9'h063);
		rd_reg(8'hf0);
		chk("busy", 9'(rdata_o), 9'h001);
		settle(6);
		rd_reg(8'hf0);
		chk("ret", 9'(rdata_o), 9'h000);
		wr_reg(8'hf7, 8'h03);
		wr_reg(8'hf8, 8'h03);
		wr_reg(8'he8, 8'h03);
		settle(3);
		@(posedge clk_sys_i);
		en <= 1;
		wait_ack;
		chk("ack", 9'({ack, grant[5:0]}), 9'h05f);
		settle(4);
		chk("equal", 9'(irq_valid_o), 9'h000);
		// second reset in mid-run clears written state
		@(posedge clk_sys_i);
		en <= 0;
		rst_n_i <= 0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1;
		rd_reg(8'hf8);
		chk("rerst", {bit_o, rdata_o}, 9'h000);
		chk("reidle", 9'(grant), 9'h000);
		rd_reg(8'he8);
		chk("rerst1", 9'(rdata_o), 9'h000);
		end_of_test;
	end
endmodule
